// ==== pws_regs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef PWS_REGS_SVH
`define PWS_REGS_SVH

`define PWS_ADDR_W 12
// Printed offsets are register indices; byte address is index times four
`define PWS_IDX_STATUS 8'hc0
`define PWS_IDX_CONTROL 8'hc2
`define PWS_IDX_MASK 8'hc3
`define PWS_IDX_IRQ_STAT 8'hc4
`define PWS_IDX_IRQ_MASK 8'hc5
`define PWS_ADDR_STATUS 12'h300
`define PWS_ADDR_CONTROL 12'h308
`define PWS_ADDR_MASK 12'h30c
`define PWS_ADDR_IRQ_STAT 12'h310
`define PWS_ADDR_IRQ_MASK 12'h314

`define PWS_ST_ACTIVITY 4
`define PWS_ST_LB2 3
`define PWS_ST_LB1 2
`define PWS_ST_OFF_CMD 8'hff

`define PWS_CT_FULL 0
`define PWS_CT_DIV8 1
`define PWS_CT_DBN 2
`define PWS_CT_RING_LSB 4
`define PWS_CT_WMASK 8'h77
`define PWS_CT_RESET 8'h10
`define PWS_MK_RESET 8'h80
`define PWS_MK_USED 8'hef

`define PWS_IRQ_ACT 0
`define PWS_IRQ_WAKE 1
`define PWS_IRQ_NMI 2
`define PWS_IRQ_W 3

`define PWS_WAKE_NONE 2'h0
`define PWS_WAKE_EXT 2'h1
`define PWS_WAKE_RTC 2'h2
`define PWS_WAKE_RI 2'h3

`define PWS_RESP_OKAY 2'h0
`define PWS_RESP_SLVERR 2'h2

`define PWS_CLK_MHZ 25
`define PWS_DBN_TIME_US 1000
`define PWS_DBN_CYCLES (`PWS_DBN_TIME_US * `PWS_CLK_MHZ)

`endif

// ==== pws_pkg.sv ====
// Types for the power state and wake control block
package pws_pkg;

    // Gray along ON, DOZE, SLEEP, SUSPEND, OFF
    typedef enum logic [2:0] {
        PWS_ON = 3'h0,
        PWS_DOZE = 3'h1,
        PWS_SLEEP = 3'h3,
        PWS_SUSPEND = 3'h2,
        PWS_OFF = 3'h6
    } pws_pstate_t;

    typedef enum logic [1:0] {
        PWS_CLK_FULL = 2'h0,
        PWS_CLK_DIV4 = 2'h1,
        PWS_CLK_DIV8 = 2'h2,
        PWS_CLK_STOP = 2'h3
    } pws_clk_t;

    typedef struct packed {
        pws_pstate_t pstate;
        logic activity;
        logic [1:0] wake_cause;
        logic [7:0] ctrl;
        logic [7:0] mask;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic irq;
        logic ri_prev;
        logic [2:0] ri_cnt;
        logic lb_prev;
        logic [15:0] dbn_cnt;
        logic dbn_done;
        logic nmi;
        pws_clk_t clk_sel;
        logic [1:0] state_code;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [11:0] waddr;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } pws_state_t;

endpackage : pws_pkg

// ==== pws_power_ctrl.sv ====
// Power state, wake cause, low battery and activity control with AXI4-Lite
`timescale 1ns/1ps
`include "pws_regs.svh"
// Function
// - Read-only two-bit wake cause: none, outside, alarm, call indicator.
// - Outside wake wins over alarm, call indicator is lowest.
// - Activity bit D4 sets on unmasked activity, cleared by writing zero.
// - Status D3 follows secondary low battery when its pin is enabled.
// - Status D2 follows primary low battery input level.
// - State bits report ON, DOZE, SLEEP, SUSPEND; reset to ON.
// - Writing state bits moves immediately into the written state.
// - Writing 0xff to status enters OFF mode.
// - Call indicator pulse count 1..7 resumes; zero disables; default one.
// - Without debounce, low battery edge raises the NMI at once.
// - With debounce, NMI only after input held about 1 ms.
// - Control D1 picks divide by 4 or 8 in DOZE and SLEEP.
// - Divisor ignored when stop clock or full speed is set.
// - Control D0 keeps processor clock at full speed in DOZE/SLEEP.
// - Activity mask selects activities that return DOZE/SLEEP to ON.
// - Mask bit 0 lets activity trigger, 1 blocks; D7 resets to 1.
module pws_power_ctrl #(
    parameter int DEBOUNCE_CYCLES = `PWS_DBN_CYCLES
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic outside_wake_input,
    input wire logic rtc_alarm_input,
    input wire logic call_indicator_input,
    input wire logic primary_battery_low_input,
    input wire logic secondary_battery_low_input,
    input wire logic secondary_battery_low_enable,
    input wire logic stop_clock_enable,
    input wire logic [7:0] activity_events,
    output logic [1:0] power_state,
    output logic off_mode,
    output pws_pkg::pws_clk_t cpu_clock_sel,
    output logic battery_low_nmi,
    output logic irq
);

    pws_pkg::pws_state_t q;
    pws_pkg::pws_state_t d;

    logic first_battery_low_level;
    logic second_battery_low_level;
    logic lb_level;
    logic wr_fire;
    logic wr_status;
    logic low_power;
    logic idle;
    logic unmasked_act;
    logic ri_edge;
    logic ri_resume;
    logic [2:0] ring;
    logic [7:0] wbyte;

    assign first_battery_low_level = primary_battery_low_input;
    assign second_battery_low_level = secondary_battery_low_input
        & secondary_battery_low_enable;
    assign lb_level = first_battery_low_level | second_battery_low_level;
    assign wr_fire = q.aw_got && q.w_got && !q.bvalid;
    assign wr_status = wr_fire && q.wstrb0
        && q.waddr == `PWS_ADDR_STATUS;
    assign wbyte = q.wdata;
    assign low_power = q.pstate == pws_pkg::PWS_SUSPEND
        || q.pstate == pws_pkg::PWS_OFF;
    assign idle = q.pstate == pws_pkg::PWS_DOZE
        || q.pstate == pws_pkg::PWS_SLEEP;
    // Reserved mask bit D4 has no source and is never honoured
    assign unmasked_act = |(activity_events & ~q.mask & `PWS_MK_USED);
    assign ring = q.ctrl[`PWS_CT_RING_LSB +: 3];
    assign ri_edge = call_indicator_input && !q.ri_prev;
    // One spare bit so a saturated count cannot wrap past the target
    assign ri_resume = ring != 3'h0 && ri_edge
        && {1'b0, q.ri_cnt} + 4'h1 >= {1'b0, ring};

    function automatic logic [1:0] code_of(input pws_pkg::pws_pstate_t s);
        case (s)
            pws_pkg::PWS_ON: code_of = 2'h0;
            pws_pkg::PWS_DOZE: code_of = 2'h1;
            pws_pkg::PWS_SLEEP: code_of = 2'h2;
            default: code_of = 2'h3;
        endcase
    endfunction : code_of

    function automatic pws_pkg::pws_pstate_t state_of(input logic [1:0] c);
        case (c)
            2'h0: state_of = pws_pkg::PWS_ON;
            2'h1: state_of = pws_pkg::PWS_DOZE;
            2'h2: state_of = pws_pkg::PWS_SLEEP;
            default: state_of = pws_pkg::PWS_SUSPEND;
        endcase
    endfunction : state_of

    always_comb begin
        logic [7:0] rbyte;
        logic [2:0] ev;
        logic hit;
        rbyte = 8'h00;
        ev = 3'h0;
        hit = 1'b1;
        d = q;

        // Power state; a software write takes precedence over wake events
        if (wr_status && wbyte == `PWS_ST_OFF_CMD) begin
            d.pstate = pws_pkg::PWS_OFF;
        end else if (wr_status) begin
            d.pstate = state_of(wbyte[1:0]);
        end else if (low_power) begin
            if (outside_wake_input) begin
                d.pstate = pws_pkg::PWS_ON;
                d.wake_cause = `PWS_WAKE_EXT;
            end else if (rtc_alarm_input) begin
                d.pstate = pws_pkg::PWS_ON;
                d.wake_cause = `PWS_WAKE_RTC;
            end else if (ri_resume) begin
                d.pstate = pws_pkg::PWS_ON;
                d.wake_cause = `PWS_WAKE_RI;
            end
        end else if (idle && unmasked_act) begin
            d.pstate = pws_pkg::PWS_ON;
        end
        if (low_power && d.pstate == pws_pkg::PWS_ON) begin
            ev[`PWS_IRQ_WAKE] = 1'b1;
        end
        d.state_code = code_of(d.pstate);

        // Call indicator pulses counted only inside one low power period
        d.ri_prev = call_indicator_input;
        if (!low_power) begin
            d.ri_cnt = 3'h0;
        end else if (ri_edge && q.ri_cnt != 3'h7) begin
            d.ri_cnt = q.ri_cnt + 3'h1;
        end

        // Activity flag; a new trigger beats a clear in the same cycle
        if (wr_status && !wbyte[`PWS_ST_ACTIVITY]) begin
            d.activity = 1'b0;
        end
        if (unmasked_act) begin
            d.activity = 1'b1;
            ev[`PWS_IRQ_ACT] = 1'b1;
        end

        // Low battery NMI, one-cycle pulse
        d.lb_prev = lb_level;
        d.nmi = 1'b0;
        if (!q.ctrl[`PWS_CT_DBN]) begin
            d.nmi = lb_level && !q.lb_prev;
            d.dbn_cnt = 16'h0000;
            d.dbn_done = 1'b0;
        end else if (!lb_level) begin
            d.dbn_cnt = 16'h0000;
            d.dbn_done = 1'b0;
        end else if (!q.dbn_done) begin
            if (q.dbn_cnt == 16'(DEBOUNCE_CYCLES - 1)) begin
                d.nmi = 1'b1;
                d.dbn_done = 1'b1;
            end else begin
                d.dbn_cnt = q.dbn_cnt + 16'h0001;
            end
        end
        ev[`PWS_IRQ_NMI] = d.nmi;

        // Processor clock choice
        if (d.pstate == pws_pkg::PWS_ON) begin
            d.clk_sel = pws_pkg::PWS_CLK_FULL;
        end else if (d.pstate == pws_pkg::PWS_DOZE
            || d.pstate == pws_pkg::PWS_SLEEP) begin
            if (q.ctrl[`PWS_CT_FULL]) begin
                d.clk_sel = pws_pkg::PWS_CLK_FULL;
            end else if (stop_clock_enable) begin
                d.clk_sel = pws_pkg::PWS_CLK_STOP;
            end else if (q.ctrl[`PWS_CT_DIV8]) begin
                d.clk_sel = pws_pkg::PWS_CLK_DIV8;
            end else begin
                d.clk_sel = pws_pkg::PWS_CLK_DIV4;
            end
        end else begin
            d.clk_sel = pws_pkg::PWS_CLK_STOP;
        end

        // AXI write channel; address and data accepted in either order
        if (s_axi_awvalid && q.awready) begin
            d.awready = 1'b0;
            d.aw_got = 1'b1;
            d.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.wready = 1'b0;
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata[7:0];
            d.wstrb0 = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            d.bvalid = 1'b1;
            d.bresp = `PWS_RESP_OKAY;
            case (q.waddr)
                `PWS_ADDR_STATUS: begin
                end
                `PWS_ADDR_CONTROL: begin
                    // Reserved bits held at zero in case software errs
                    if (q.wstrb0) begin
                        d.ctrl = wbyte & `PWS_CT_WMASK;
                    end
                end
                `PWS_ADDR_MASK: begin
                    if (q.wstrb0) begin
                        d.mask = wbyte;
                    end
                end
                `PWS_ADDR_IRQ_STAT: begin
                    if (q.wstrb0) begin
                        d.irq_stat = q.irq_stat & ~wbyte[2:0];
                    end
                end
                `PWS_ADDR_IRQ_MASK: begin
                    if (q.wstrb0) begin
                        d.irq_mask = wbyte[2:0];
                    end
                end
                default: d.bresp = `PWS_RESP_SLVERR;
            endcase
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.awready = 1'b1;
            d.wready = 1'b1;
        end

        // Sticky events win over a write-one clear
        d.irq_stat = d.irq_stat | ev;
        d.irq = |(d.irq_stat & d.irq_mask);

        // AXI read channel
        if (s_axi_arvalid && q.arready) begin
            case (s_axi_araddr)
                `PWS_ADDR_STATUS: rbyte = {1'b0, q.wake_cause, q.activity,
                    second_battery_low_level, first_battery_low_level,
                    q.state_code};
                `PWS_ADDR_CONTROL: rbyte = q.ctrl;
                `PWS_ADDR_MASK: rbyte = q.mask;
                `PWS_ADDR_IRQ_STAT: rbyte = {5'h00, q.irq_stat};
                `PWS_ADDR_IRQ_MASK: rbyte = {5'h00, q.irq_mask};
                default: hit = 1'b0;
            endcase
            d.arready = 1'b0;
            d.rvalid = 1'b1;
            d.rdata = {24'h000000, rbyte};
            d.rresp = hit ? `PWS_RESP_OKAY : `PWS_RESP_SLVERR;
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
            d.arready = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= '0;
            q.pstate <= pws_pkg::PWS_ON;
            q.ctrl <= `PWS_CT_RESET;
            q.mask <= `PWS_MK_RESET;
            q.clk_sel <= pws_pkg::PWS_CLK_FULL;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = q.rdata;
    assign power_state = q.state_code;
    // OFF is the only state code with bit 2 set
    assign off_mode = q.pstate[2];
    assign cpu_clock_sel = q.clk_sel;
    assign battery_low_nmi = q.nmi;
    assign irq = q.irq;

    AST_ACT_SET: assert property (@(posedge ref_clk) disable iff (srst)
        unmasked_act |=> q.activity) else $error("activity not set");
    AST_ACT_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
        q.activity && !(wr_status && !wbyte[`PWS_ST_ACTIVITY])
        |=> q.activity) else $error("activity lost");
    AST_OFF_CMD: assert property (@(posedge ref_clk) disable iff (srst)
        wr_status && wbyte == `PWS_ST_OFF_CMD |=> off_mode
        && power_state == 2'h3) else $error("no off mode");
    AST_WR_STATE: assert property (@(posedge ref_clk) disable iff (srst)
        wr_status && wbyte != `PWS_ST_OFF_CMD
        |=> power_state == $past(wbyte[1:0]))
        else $error("state write lost");
    AST_EXT_FIRST: assert property (@(posedge ref_clk) disable iff (srst)
        low_power && outside_wake_input && !wr_status
        |=> power_state == 2'h0 && q.wake_cause == `PWS_WAKE_EXT)
        else $error("outside wake not first");
    AST_RI_OFF: assert property (@(posedge ref_clk) disable iff (srst)
        low_power && ring == 3'h0 && !outside_wake_input
        && !rtc_alarm_input && !wr_status |=> power_state == 2'h3)
        else $error("call indicator resumed while disabled");
    AST_RI_RESTART: assert property (@(posedge ref_clk) disable iff (srst)
        !low_power ##1 low_power |-> q.ri_cnt == 3'h0)
        else $error("pulse count not restarted");
    AST_NMI_EDGE: assert property (@(posedge ref_clk) disable iff (srst)
        !q.ctrl[`PWS_CT_DBN] && lb_level && !q.lb_prev |=> battery_low_nmi)
        else $error("edge nmi missing");
    AST_NMI_DBN: assert property (@(posedge ref_clk) disable iff (srst)
        q.ctrl[`PWS_CT_DBN] && lb_level && !q.lb_prev && DEBOUNCE_CYCLES > 2
        |=> !battery_low_nmi [*2]) else $error("nmi not debounced");
    AST_CLK_FULL: assert property (@(posedge ref_clk) disable iff (srst)
        q.ctrl[`PWS_CT_FULL] && idle && !wr_fire && !unmasked_act
        |=> cpu_clock_sel == pws_pkg::PWS_CLK_FULL)
        else $error("full speed not held");
    AST_CLK_DIV: assert property (@(posedge ref_clk) disable iff (srst)
        idle && !q.ctrl[`PWS_CT_FULL] && !stop_clock_enable && !wr_fire
        && !unmasked_act |=> cpu_clock_sel == (q.ctrl[`PWS_CT_DIV8]
        ? pws_pkg::PWS_CLK_DIV8 : pws_pkg::PWS_CLK_DIV4))
        else $error("wrong divisor");
    AST_MASKED: assert property (@(posedge ref_clk) disable iff (srst)
        idle && !unmasked_act && !wr_status |=> $stable(power_state))
        else $error("masked activity woke");

endmodule : pws_power_ctrl

// ==== pws_far_model.sv ====
// Far-side model of wake, call indicator, battery and activity sources
`timescale 1ns/1ps
module pws_far_model (
    input wire logic ref_clk,
    input wire logic [6:0] lvl_set,
    input wire logic [7:0] act_set,
    input wire logic [7:0] ring_req,
    output logic [6:0] lvl,
    output logic [7:0] act,
    output logic ring_busy
);
    logic [7:0] ring_done;
    logic [1:0] ph;
    initial begin
        lvl = 7'h00;
        act = 8'h00;
        ring_done = 8'h00;
        ph = 2'h0;
    end
    assign ring_busy = ring_done != ring_req;
    // Levels {ext, alarm, call, lb1, lb2, lb2 en, stop}, one cycle behind
    // Call pulses two cycles high, two low: slow enough for edge counting
    always @(posedge ref_clk) begin
        act <= act_set;
        lvl <= {lvl_set[6:5], lvl_set[4] | (ring_busy && !ph[1]),
            lvl_set[3:0]};
        if (ring_busy) begin
            ph <= ph + 2'h1;
            if (ph == 2'h3) begin
                ring_done <= ring_done + 8'h01;
            end
        end
    end
endmodule : pws_far_model

// ==== power_state_wake_control_bench.sv ====
// Self-checking bench for the power state and wake control block
`timescale 1ns/1ps
`include "pws_regs.svh"
module power_state_wake_control_bench;
    logic ref_clk, srst, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, s_rdata, rd;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid, irq, off_mode, nmi;
    logic [1:0] bresp, rresp, pstate, s_rresp, rr;
    logic s_aw, s_w, s_b, s_ar, s_r;
    pws_pkg::pws_clk_t clk_sel;
    logic [6:0] lvl, lvl_set;
    logic [7:0] act, act_set, ring_req;
    logic [1:0] s_bresp, br;
    logic ring_busy;
    int fails, check_count, nmi_cnt;
    logic [7:0] cv [5] = '{8'h10, 8'h12, 8'h13, 8'h12, 8'h11};
    logic [6:0] sv [5] = '{7'h00, 7'h00, 7'h00, 7'h01, 7'h01};
    pws_pkg::pws_clk_t ev [5] = '{pws_pkg::PWS_CLK_DIV4,
        pws_pkg::PWS_CLK_DIV8, pws_pkg::PWS_CLK_FULL,
        pws_pkg::PWS_CLK_STOP, pws_pkg::PWS_CLK_FULL};

    pws_power_ctrl #(.DEBOUNCE_CYCLES(8)) i_pws_power_ctrl (
        .ref_clk(ref_clk), .srst(srst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .outside_wake_input(lvl[6]), .rtc_alarm_input(lvl[5]),
        .call_indicator_input(lvl[4]), .primary_battery_low_input(lvl[3]),
        .secondary_battery_low_input(lvl[2]),
        .secondary_battery_low_enable(lvl[1]), .stop_clock_enable(lvl[0]),
        .activity_events(act), .power_state(pstate), .off_mode(off_mode),
        .cpu_clock_sel(clk_sel), .battery_low_nmi(nmi), .irq(irq)
    );
    pws_far_model i_pws_far_model (
        .ref_clk(ref_clk), .lvl_set(lvl_set), .act_set(act_set),
        .ring_req(ring_req), .lvl(lvl), .act(act), .ring_busy(ring_busy)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Registered outputs are stable at the falling edge: no edge race
    always @(negedge ref_clk) begin
        {s_aw, s_w, s_b, s_ar, s_r} <= {awready, wready, bvalid, arready, rvalid};
        s_rresp <= rresp;
        s_bresp <= bresp;
        s_rdata <= rdata;
        if (nmi === 1'b1) nmi_cnt <= nmi_cnt + 1;
    end

    task automatic close_out;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic guard(inout int n);
        n++;
        if (n > 100) begin
            fails++;
            close_out();
        end
    endtask : guard
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            guard(n);
            if (s_aw) awvalid <= 1'b0;
            if (s_w) wvalid <= 1'b0;
            if (s_b) bready <= 1'b0;
        end while (s_b !== 1'b1);
        br = s_bresp;
    endtask : wr
    task automatic rd_reg(input logic [11:0] a);
        int n;
        n = 0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            guard(n);
            if (s_ar) arvalid <= 1'b0;
        end while (s_r !== 1'b1);
        rready <= 1'b0;
        rd = s_rdata;
        rr = s_rresp;
    endtask : rd_reg
    task automatic rchk(input logic [11:0] a, input string nm,
                        input logic [31:0] exp);
        rd_reg(a);
        check(nm, rd, exp);
        check("rresp", 32'(rr), 32'h00000000);
    endtask : rchk
    task automatic levels(input logic [6:0] v);
        @(posedge ref_clk);
        lvl_set <= v;
        @(posedge ref_clk);
    endtask : levels
    task automatic pulse_act(input logic [7:0] e);
        @(posedge ref_clk);
        act_set <= e;
        @(posedge ref_clk);
        act_set <= 8'h00;
    endtask : pulse_act
    task automatic ring(input logic [7:0] n);
        @(posedge ref_clk);
        ring_req <= ring_req + n;
        do @(negedge ref_clk); while (ring_busy);
        @(posedge ref_clk);
    endtask : ring

    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        close_out();
    end

    initial begin
        {srst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata} = '0;
        {lvl_set, act_set, ring_req} = '0;
        wstrb = 4'h1;
        {fails, check_count, nmi_cnt} = '0;
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        rchk(`PWS_ADDR_STATUS, "status", 32'h00);
        rchk(`PWS_ADDR_CONTROL, "control", 32'h10);
        rchk(`PWS_ADDR_MASK, "mask", 32'h80);
        rd_reg(12'h3fc);
        check("unmapped resp", 32'(rr), 32'h2);
        check("unmapped data", rd, 32'h0);
        wr(12'h3fc, 8'h00);
        check("unmapped bresp", 32'(br), 32'h2);
        wstrb <= 4'h0;
        wr(`PWS_ADDR_CONTROL, 8'h77);
        check("no strobe bresp", 32'(br), 32'h0);
        wstrb <= 4'h1;
        rchk(`PWS_ADDR_CONTROL, "no strobe", 32'h10);
        // Battery levels, undebounced and debounced NMI
        levels(7'h08);
        repeat (3) @(posedge ref_clk);
        rchk(`PWS_ADDR_STATUS, "lb1 level", 32'h04);
        check("nmi lb1", nmi_cnt, 32'h1);
        levels(7'h04);
        rchk(`PWS_ADDR_STATUS, "lb2 off", 32'h00);
        check("nmi lb2 off", nmi_cnt, 32'h1);
        levels(7'h06);
        rchk(`PWS_ADDR_STATUS, "lb2 on", 32'h08);
        check("nmi lb2 on", nmi_cnt, 32'h2);
        levels(7'h00);
        wr(`PWS_ADDR_CONTROL, 8'h14);
        levels(7'h08);
        repeat (4) @(posedge ref_clk);
        check("nmi early", nmi_cnt, 32'h2);
        repeat (12) @(posedge ref_clk);
        check("nmi held", nmi_cnt, 32'h3);
        // Divisor, full speed and stop clock in DOZE and SLEEP
        for (int i = 0; i < 5; i++) begin
            levels(sv[i]);
            wr(`PWS_ADDR_CONTROL, cv[i]);
            wr(`PWS_ADDR_STATUS, 8'(1 + i % 2));
            repeat (2) @(posedge ref_clk);
            @(negedge ref_clk);
            check("clk sel", 32'(clk_sel), 32'(ev[i]));
            check("pstate", 32'(pstate), 32'(1 + i % 2));
            rchk(`PWS_ADDR_STATUS, "state", 32'(1 + i % 2));
        end
        levels(7'h00);
        // Activity masking, sticky status, interrupt
        wr(`PWS_ADDR_MASK, 8'h01);
        pulse_act(8'h01);
        repeat (3) @(posedge ref_clk);
        rchk(`PWS_ADDR_STATUS, "masked act", 32'h01);
        pulse_act(8'h80);
        repeat (3) @(posedge ref_clk);
        rchk(`PWS_ADDR_STATUS, "act wake", 32'h10);
        rchk(`PWS_ADDR_IRQ_STAT, "irq stat", 32'h05);
        @(negedge ref_clk);
        check("irq masked", 32'(irq), 32'h0);
        wr(`PWS_ADDR_IRQ_MASK, 8'h01);
        @(negedge ref_clk);
        check("irq on", 32'(irq), 32'h1);
        wr(`PWS_ADDR_IRQ_STAT, 8'h01);
        @(negedge ref_clk);
        check("irq clr", 32'(irq), 32'h0);
        wr(`PWS_ADDR_STATUS, 8'h10);
        rchk(`PWS_ADDR_STATUS, "act kept", 32'h10);
        wr(`PWS_ADDR_STATUS, 8'h00);
        rchk(`PWS_ADDR_STATUS, "act clr", 32'h00);
        // Wake causes, priority and call counting
        wr(`PWS_ADDR_STATUS, 8'hff);
        @(negedge ref_clk);
        check("off mode", 32'(off_mode), 32'h1);
        check("off state", 32'(pstate), 32'h3);
        levels(7'h60);
        repeat (3) @(posedge ref_clk);
        rchk(`PWS_ADDR_STATUS, "ext wins", 32'h20);
        levels(7'h00);
        wr(`PWS_ADDR_STATUS, 8'h03);
        levels(7'h20);
        repeat (3) @(posedge ref_clk);
        rchk(`PWS_ADDR_STATUS, "alarm", 32'h40);
        levels(7'h00);
        wr(`PWS_ADDR_CONTROL, 8'h30);
        wr(`PWS_ADDR_STATUS, 8'h03);
        ring(8'h02);
        rchk(`PWS_ADDR_STATUS, "two calls", 32'h43);
        ring(8'h01);
        rchk(`PWS_ADDR_STATUS, "third call", 32'h60);
        wr(`PWS_ADDR_STATUS, 8'h03);
        ring(8'h02);
        wr(`PWS_ADDR_STATUS, 8'h00);
        wr(`PWS_ADDR_STATUS, 8'h03);
        ring(8'h02);
        rchk(`PWS_ADDR_STATUS, "count restart", 32'h63);
        wr(`PWS_ADDR_CONTROL, 8'h10);
        wr(`PWS_ADDR_STATUS, 8'h03);
        levels(7'h30);
        repeat (3) @(posedge ref_clk);
        rchk(`PWS_ADDR_STATUS, "alarm over call", 32'h40);
        levels(7'h00);
        wr(`PWS_ADDR_CONTROL, 8'h00);
        wr(`PWS_ADDR_STATUS, 8'h03);
        ring(8'h08);
        rchk(`PWS_ADDR_STATUS, "calls disabled", 32'h43);
        close_out();
    end
endmodule : power_state_wake_control_bench
